// *** hdl/aer_cfg.svh ***
// Purpose: Offsets, field positions and reset values of the error register
//   pair.
// Assumes: Byte addresses on a 32-bit configuration access port.
// Notes: Summary of operation follows.
// Summary of operation
// R01: Severity bits 20,19,15,14,12 sticky, reset 0.
// R02: Severity bits 18,17,13 sticky, reset 1.
// R03: Severity bits 5,4 sticky, reset 1.
// R04: Software keeps unexpected completion severity cleared.
// R05: Severity bit 0 reserved, reads zero.
// R06: Correctable flags sticky, reset 0, write-one clears.
// R07: Replay timer expiry and rollover set flags.
// R08: Link packet CRC mismatch sets bad link flag.
// R09: Physical layer error sets bad transaction flag.
// R10: End-bad packet without inverted CRC sets flag.
// R11: Transaction packet CRC mismatch sets flag.
// R12: Legacy mode makes registers read as reserved.
// R13: Sticky bits survive all but power-on reset.
`ifndef AER_CFG_SVH
`define AER_CFG_SVH
`define AER_SEV_OFFSET 12'h10c
`define AER_COR_OFFSET 12'h110
`define AER_SEV_RESET 32'h00062030
`define AER_SEV_MASK 32'h001ff030
`define AER_COR_RESET 32'h00000000
`define AER_COR_MASK 32'h000031c1
`define AER_BIT_ANF 13
`define AER_BIT_RTO 12
`define AER_BIT_RRO 8
`define AER_BIT_BLP 7
`define AER_BIT_BTP 6
`define AER_BIT_RXE 0
`endif

// *** hdl/aer_pkg.sv ***
// Purpose: Types shared by the error register pair.
// Assumes: Nothing beyond the configuration header.
// Notes: Register words are 32 bits wide.
package aer_pkg;
  typedef logic [31:0] aer_word_t;
  typedef logic [11:0] aer_addr_t;
endpackage : aer_pkg

// *** hdl/aer_sev_reg.sv ***
// Purpose: Sticky read/write severity register.
// Assumes: Only power-on reset returns it to its reset value.
// Notes: Reserved bits are held at zero.
`include "aer_cfg.svh"
module aer_sev_reg
  import aer_pkg::*;
(
  // Clock and power-on reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Write port.
  input wire logic i_wr,
  input wire aer_word_t i_wdata,
  // Stored value.
  output aer_word_t o_value
);
  typedef struct packed {
    aer_word_t sev;
  } aer_sev_s;
  aer_sev_s st;
  aer_sev_s next_st;
  always_comb
  begin
    next_st = st;
    if (i_wr)
    begin
      next_st.sev = i_wdata & `AER_SEV_MASK; // R01 R02 R03 R05 R13
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st.sev <= `AER_SEV_RESET; // R01 R02 R03 R13
    end
    else
    begin
      st <= next_st;
    end
  end
  assign o_value = st.sev;
endmodule : aer_sev_reg

// *** hdl/aer_cor_reg.sv ***
// Purpose: Sticky write-one-to-clear correctable status register.
// Assumes: Event inputs are one-cycle pulses on the core clock.
// Notes: A set arriving with a clear wins.
`include "aer_cfg.svh"
module aer_cor_reg
  import aer_pkg::*;
(
  // Clock and power-on reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Write-one-to-clear port.
  input wire logic i_wr,
  input wire aer_word_t i_wdata,
  // Set vector.
  input wire aer_word_t i_set,
  // Stored value.
  output aer_word_t o_value
);
  typedef struct packed {
    aer_word_t cor;
  } aer_cor_s;
  aer_cor_s st;
  aer_cor_s next_st;
  aer_word_t clr;
  always_comb
  begin
    next_st = st;
    clr = i_wr ? i_wdata : 32'h00000000;
    next_st.cor = ((st.cor & ~clr) | i_set) & `AER_COR_MASK; // R06 R13
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st.cor <= `AER_COR_RESET; // R06 R13
    end
    else
    begin
      st <= next_st;
    end
  end
  assign o_value = st.cor;
endmodule : aer_cor_reg

// *** hdl/aer_regs.sv ***
// Purpose: Severity and correctable status registers of error reporting.
// Assumes: Configuration access on the core clock; link events are pulses.
// Notes: i_rst_n is the power-on reset; hot and warm resets do not reach
//   the sticky bits. Legacy mode is a level that may change any time.
`include "aer_cfg.svh"
module aer_regs
  import aer_pkg::*;
(
  // Clock and power-on reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Hot or warm reset, ignored by sticky state.
  input wire logic i_warm_rst,
  // Mode strap, from a pin.
  input wire logic i_legacy_mode,
  // Configuration access.
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire aer_addr_t i_cfg_addr,
  input wire aer_word_t i_cfg_wdata,
  output aer_word_t o_cfg_rdata,
  output logic o_cfg_ack,
  // Link-layer events.
  input wire logic i_advisory_nonfatal,
  input wire logic i_replay_timer_expired,
  input wire logic i_replay_count_wrapped,
  input wire logic i_link_crc_mismatch,
  input wire logic i_phy_packet_error,
  input wire logic i_end_bad_packet,
  input wire logic i_end_bad_crc_inverted,
  input wire logic i_packet_crc_mismatch,
  input wire logic i_receiver_error,
  // Register contents for the error logic.
  output aer_word_t o_severity,
  output aer_word_t o_cor_status
);
  // Decoded form of one configuration cycle.
  typedef struct packed {
    logic rd;
    logic wr;
    logic sev;
    logic cor;
  } aer_dec_s;

  // Access pipeline and mode synchroniser. The sticky bits live in the two
  // register modules, so nothing here has to survive a warm reset.
  typedef struct packed {
    logic legacy_s1;
    logic legacy;
    aer_word_t rdata;
    logic ack;
  } aer_top_s;

  aer_top_s st;
  aer_top_s next_st;
  aer_dec_s dec;
  aer_word_t sev_value;
  aer_word_t cor_value;
  aer_word_t set_vec;
  logic regs_live;
  logic sev_wr;
  logic cor_wr;
  logic ev_anf;
  logic ev_rto;
  logic ev_rro;
  logic ev_blp;
  logic ev_btp;
  logic ev_rxe;
  logic btp_phy;
  logic btp_edb;
  logic btp_crc;

  // True when the byte address selects the given register.
  function automatic logic aer_hit(input aer_addr_t a, input aer_addr_t o);
    aer_hit = (a == o);
  endfunction : aer_hit

  // Splits a configuration cycle into strobes and register selects. While
  // the group is dormant no select is raised, so reads return zero and
  // writes are dropped, yet the strobes still earn an acknowledge.
  function automatic aer_dec_s aer_decode(
    input logic rd,
    input logic wr,
    input aer_addr_t a,
    input logic live
  );
    aer_dec_s d;
    d.rd = rd;
    d.wr = wr;
    d.sev = live && aer_hit(a, `AER_SEV_OFFSET);
    d.cor = live && aer_hit(a, `AER_COR_OFFSET);
    aer_decode = d;
  endfunction : aer_decode

  // Places one event at its field position in an otherwise empty word.
  function automatic aer_word_t aer_flag(
    input int unsigned pos,
    input logic v
  );
    aer_word_t w;
    w = 32'h00000000;
    w[pos[4:0]] = v;
    aer_flag = w;
  endfunction : aer_flag

  // Reserved severity positions read zero even if storage misbehaves.
  function automatic aer_word_t aer_sev_view(input aer_word_t v);
    aer_sev_view = v & `AER_SEV_MASK;
  endfunction : aer_sev_view

  // Reserved status positions read zero even if storage misbehaves.
  function automatic aer_word_t aer_cor_view(input aer_word_t v);
    aer_cor_view = v & `AER_COR_MASK;
  endfunction : aer_cor_view

  // Chooses the word returned by a read; unselected addresses read zero.
  function automatic aer_word_t aer_read_word(
    input aer_dec_s d,
    input aer_word_t sev,
    input aer_word_t cor
  );
    aer_word_t w;
    w = 32'h00000000;
    if (d.rd && d.sev)
    begin
      w = aer_sev_view(sev);
    end
    else if (d.rd && d.cor)
    begin
      w = aer_cor_view(cor);
    end
    aer_read_word = w;
  endfunction : aer_read_word

  // A packet that ended bad is judged only by its inverted check value;
  // the plain check comparison applies to packets that ended normally.
  assign btp_phy = i_phy_packet_error; // R09
  assign btp_edb = i_end_bad_packet && !i_end_bad_crc_inverted; // R10
  assign btp_crc = !i_end_bad_packet && i_packet_crc_mismatch; // R11
  assign ev_anf = i_advisory_nonfatal; // R06
  assign ev_rto = i_replay_timer_expired; // R07
  assign ev_rro = i_replay_count_wrapped; // R07
  assign ev_blp = i_link_crc_mismatch; // R08
  assign ev_btp = btp_phy || btp_edb || btp_crc; // R09 R10 R11
  assign ev_rxe = i_receiver_error; // R06

  assign set_vec = aer_flag(`AER_BIT_ANF, ev_anf)
    | aer_flag(`AER_BIT_RTO, ev_rto)
    | aer_flag(`AER_BIT_RRO, ev_rro)
    | aer_flag(`AER_BIT_BLP, ev_blp)
    | aer_flag(`AER_BIT_BTP, ev_btp)
    | aer_flag(`AER_BIT_RXE, ev_rxe);

  // Legacy mode is only ever read after its second synchroniser stage.
  assign regs_live = !st.legacy; // R12
  assign dec = aer_decode(i_cfg_rd, i_cfg_wr, i_cfg_addr, regs_live);
  assign sev_wr = dec.wr && dec.sev; // R12
  assign cor_wr = dec.wr && dec.cor; // R12

  aer_sev_reg u_sev (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(sev_wr),
    .i_wdata(i_cfg_wdata),
    .o_value(sev_value)
  );

  aer_cor_reg u_cor (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(cor_wr),
    .i_wdata(i_cfg_wdata),
    .i_set(set_vec),
    .o_value(cor_value)
  );

  always_comb
  begin
    next_st = st;
    next_st.legacy_s1 = i_legacy_mode;
    next_st.legacy = st.legacy_s1;
    next_st.ack = dec.rd || dec.wr;
    next_st.rdata = aer_read_word(dec, sev_value, cor_value); // R05 R12
  end

  // Warm reset is accepted but deliberately leaves all state alone.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st; // R13
    end
  end

  assign o_cfg_rdata = st.rdata;
  assign o_cfg_ack = st.ack;
  assign o_severity = sev_value;
  assign o_cor_status = cor_value;
endmodule : aer_regs

// *** sim/aer_regs_props.sv ***
// Purpose: Port checks of the error register pair.
// Assumes: One clock; i_rst_n is the power-on reset.
// Notes: Bound from the bench top.
module aer_regs_props
  import aer_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Access.
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic o_cfg_ack,
  // Events.
  input wire logic i_advisory_nonfatal,
  input wire logic i_replay_timer_expired,
  input wire logic i_replay_count_wrapped,
  input wire logic i_link_crc_mismatch,
  input wire logic i_phy_packet_error,
  input wire logic i_end_bad_packet,
  input wire logic i_end_bad_crc_inverted,
  input wire logic i_packet_crc_mismatch,
  input wire logic i_receiver_error,
  // Contents.
  input wire aer_word_t o_severity,
  input wire aer_word_t o_cor_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_ack_timed: assert property (o_cfg_ack == $past(i_cfg_rd || i_cfg_wr))
    else $error("ack timing");
  a_anf_set: assert property (i_advisory_nonfatal |=> o_cor_status[13])
    else $error("anf");
  a_rto_set: assert property (
    i_replay_timer_expired |=> o_cor_status[12])
    else $error("rto");
  a_rro_set: assert property (
    i_replay_count_wrapped |=> o_cor_status[8])
    else $error("rro");
  a_rxe_set: assert property (i_receiver_error |=> o_cor_status[0])
    else $error("rxe");
  a_blp_set: assert property (i_link_crc_mismatch |=> o_cor_status[7])
    else $error("blp");
  a_btp_phy: assert property (i_phy_packet_error |=> o_cor_status[6])
    else $error("btp phy");
  a_btp_edb: assert property (
    i_end_bad_packet && !i_end_bad_crc_inverted |=> o_cor_status[6])
    else $error("btp edb");
  a_btp_crc: assert property (
    i_packet_crc_mismatch && !i_end_bad_packet |=> o_cor_status[6])
    else $error("btp crc");
  a_sev_resv: assert property ((o_severity & 32'hffe00fcf) == 32'h0)
    else $error("sev reserved");
  a_cor_resv: assert property ((o_cor_status & 32'hffffce3e) == 32'h0)
    else $error("cor reserved");
  cover property (i_end_bad_packet && i_end_bad_crc_inverted);
  cover property (i_cfg_wr ##1 o_cfg_ack);
  cover property (o_cor_status[6]);
endmodule : aer_regs_props

// *** sim/tb_aer_regs.sv ***
// Purpose: Register-level test of the error register pair.
// Assumes: Access acknowledged one cycle after the strobe.
// Notes: Inputs change 1 ns after the rising edge.
module tb_aer_regs
  import aer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst_n = 0, warm = 0, leg = 0, wr = 0, rd = 0, ack;
  aer_addr_t addr = '0;
  aer_word_t wdata = '0, rdata, sev_out, cor_out;
  logic [8:0] ev = '0;
  int miscompares = 0, tests_run = 0, cyc = 0;
  logic [8:0] pat [11] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010,
    9'h020, 9'h040, 9'h060, 9'h080, 9'h100, 9'h0e0};
  logic [15:0] ex [11] = '{16'h2000, 16'h1000, 16'h0100, 16'h0080,
    16'h0040, 16'h0040, 16'h0000, 16'h0000, 16'h0040, 16'h0001, 16'h0000};
  always #20 i_clk = ~i_clk;
  aer_regs uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_warm_rst(warm),
    .i_legacy_mode(leg), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
    .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
    .i_advisory_nonfatal(ev[0]), .i_replay_timer_expired(ev[1]),
    .i_replay_count_wrapped(ev[2]), .i_link_crc_mismatch(ev[3]),
    .i_phy_packet_error(ev[4]), .i_end_bad_packet(ev[5]),
    .i_end_bad_crc_inverted(ev[6]), .i_packet_crc_mismatch(ev[7]),
    .i_receiver_error(ev[8]), .o_severity(sev_out),
    .o_cor_status(cor_out));
  task close_out;
    $display("checks %0d errors %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task chk(input string n, input aer_word_t e, input aer_word_t s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task acc(input logic w, input aer_addr_t a, input aer_word_t d);
    @(posedge i_clk) #1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge i_clk) #1;
    wr = 0;
    rd = 0;
    chk("ack", 32'h1, {31'h0, ack});
  endtask : acc
  task rdc(input string n, input aer_addr_t a, input aer_word_t e);
    acc(0, a, '0);
    chk(n, e, rdata);
  endtask : rdc
  task pulse(input logic [8:0] p);
    @(posedge i_clk) #1;
    ev = p;
    @(posedge i_clk) #1;
    ev = '0;
  endtask : pulse
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      miscompares++;
      close_out();
    end
  end
  initial
  begin
    repeat (20) @(posedge i_clk);
    #1 i_rst_n = 1;
    rdc("sev", 12'h10c, 32'h00062030);
    rdc("cor", 12'h110, 32'h0);
    acc(1, 12'h10c, 32'hfffeffff);
    rdc("sev", 12'h10c, 32'h001ef030);
    acc(1, 12'h10c, 32'h0);
    rdc("sev", 12'h10c, 32'h0);
    for (int i = 0; i < 11; i++)
    begin
      pulse(pat[i]);
      chk("cor out", {16'h0, ex[i]}, cor_out);
      rdc("cor", 12'h110, {16'h0, ex[i]});
      acc(1, 12'h110, 32'hffffffff);
      rdc("cor", 12'h110, 32'h0);
    end
    pulse(9'h106);
    acc(1, 12'h110, 32'h00001000);
    rdc("cor", 12'h110, 32'h00000101);
    acc(1, 12'h10c, 32'h00042010);
    chk("sev out", 32'h00042010, sev_out);
    warm = 1;
    repeat (3) @(posedge i_clk);
    #1 warm = 0;
    rdc("sev", 12'h10c, 32'h00042010);
    rdc("cor", 12'h110, 32'h00000101);
    leg = 1;
    repeat (4) @(posedge i_clk);
    rdc("sev", 12'h10c, 32'h0);
    acc(1, 12'h10c, 32'h0);
    acc(1, 12'h110, 32'hffffffff);
    leg = 0;
    repeat (4) @(posedge i_clk);
    rdc("sev", 12'h10c, 32'h00042010);
    rdc("cor", 12'h110, 32'h00000101);
    rdc("unmapped", 12'h114, 32'h0);
    i_rst_n = 0;
    @(posedge i_clk) #1 i_rst_n = 1;
    rdc("sev", 12'h10c, 32'h00062030);
    rdc("cor", 12'h110, 32'h0);
    chk("sev out", 32'h00062030, sev_out);
    chk("cor out", 32'h0, cor_out);
    close_out();
  end
endmodule : tb_aer_regs
bind aer_regs aer_regs_props u_props (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_cfg_wr(i_cfg_wr),
  .i_cfg_rd(i_cfg_rd),
  .o_cfg_ack(o_cfg_ack),
  .i_advisory_nonfatal(i_advisory_nonfatal),
  .i_replay_timer_expired(i_replay_timer_expired),
  .i_replay_count_wrapped(i_replay_count_wrapped),
  .i_link_crc_mismatch(i_link_crc_mismatch),
  .i_phy_packet_error(i_phy_packet_error),
  .i_end_bad_packet(i_end_bad_packet),
  .i_end_bad_crc_inverted(i_end_bad_crc_inverted),
  .i_packet_crc_mismatch(i_packet_crc_mismatch),
  .i_receiver_error(i_receiver_error),
  .o_severity(o_severity),
  .o_cor_status(o_cor_status)
);
